/* design/adcsp_defines.svh */
`ifndef ADCSP_DEFINES_SVH
`define ADCSP_DEFINES_SVH
// How it works
// - mode select value 3 picks the serial port; any other value picks parallel
// - outside serial mode the divider pins drive result bits 4 and 5
// - outside serial mode clock, polarity and read-mode pins drive result bits 6 to 9
// - divider pins slow the internal bit clock only in master read-after-convert
// - clock source low: bit clock made internally and driven out on its pin
// - clock source high: host supplies bit clock, data shifts on its edges
// - frame polarity low gives active-high frame marker, high gives active-low
// - bit clock invert flips the bit clock for internal and external sourcing
// - with external clock the read-mode pin becomes the chain input
// - chain input data reaches the serial output 18 bit periods after start
// - internal clock, read-mode high: previous result shifts out during conversion
// - internal clock, read-mode low: result shifts out only after conversion ends
// - each result leaves the shift register most significant bit first
// - internal clock: frame marker asserts at read start and holds while output data is valid; external clock keeps it inactive
// - data updates on bit clock rising edge, valid on falling; invert swaps edges

// ************************************************************
// register map and fields
// ************************************************************
`define ADCSP_OFS_CTRL 4'h0
`define ADCSP_OFS_DATA 4'h4
`define ADCSP_OFS_STAT 4'h8
`define ADCSP_CTRL_START_BIT 2
`define ADCSP_MODE_SERIAL 2'h3
`define ADCSP_MODE_RESET 2'h0
`define ADCSP_RES_W 18
`define ADCSP_LAST_BIT 5'h11
`define ADCSP_FIFO_DEPTH 16
`define ADCSP_FIFO_AW 4

// ************************************************************
// timing
// ************************************************************
`define ADCSP_CLK_MHZ 25
`define ADCSP_CONV_NS 1000
`define ADCSP_CONV_CYC ((`ADCSP_CONV_NS * `ADCSP_CLK_MHZ + 999) / 1000)
`define ADCSP_BASE_HALF 8'h01
`endif

/* design/adcsp_pkg.sv */
package adcsp_pkg;
  // serial configuration as seen on the shared pins, bit 4 upward
  typedef struct packed {
    logic read_mode;
    logic inv_sclk;
    logic inv_sync;
    logic ext;
    logic [1:0] div;
  } adcsp_cfg_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [31:0] wdata;
  } adcsp_bus_type;

  typedef enum {ST_IDLE, ST_SHIFT} adcsp_state_type;
endpackage

/* design/adcsp_fifo.sv */
`timescale 1ns/100ps
module adcsp_fifo #(
  parameter int W = 18,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic in_valid, // push request
  output logic in_ready, // room available
  input wire logic [W-1:0] in_data, // push data
  output logic out_valid, // data available
  input wire logic out_ready, // pop request
  output logic [W-1:0] out_data, // head word
  output logic [AW:0] count // fill level
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign count = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* design/adcsp_sclk_gen.sv */
`timescale 1ns/100ps
`include "adcsp_defines.svh"
module adcsp_sclk_gen (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic run, // generate while high
  input wire logic slow, // apply divider
  input wire logic [1:0] div, // divider select
  output logic sclk_d, // next clock level
  output logic rise // clock rises at next edge
);
  logic sclk_q;
  logic [7:0] cnt_q;
  logic [7:0] half;
  logic flip;

  // half period doubles per divider step when slowing applies
  assign half = slow ? (`ADCSP_BASE_HALF << div) : `ADCSP_BASE_HALF;
  assign flip = run && (cnt_q >= half - 8'h01);
  assign sclk_d = run ? (flip ? ~sclk_q : sclk_q) : 1'b0;
  assign rise = sclk_d && !sclk_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      sclk_q <= sclk_d;
      cnt_q <= (!run || flip) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule

/* design/adcsp_top.sv */
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "adcsp_defines.svh"
module adcsp_top
  import adcsp_pkg::*;
(
  input wire logic MCLK, // system clock
  input wire logic RST, // sync reset, active high
  input wire logic [3:0] ADDR, // byte address
  input wire logic READ, // read request
  input wire logic WRITE, // write request
  input wire logic [31:0] WRITEDATA, // write data
  output logic [31:0] READDATA, // read data
  output logic WAITREQUEST, // stall
  input wire logic [5:0] PD_I, // shared pins 4..9, input
  output logic [5:0] PD_O, // shared pins 4..9, output
  output logic [5:0] PD_OE, // shared pins 4..9, enable
  input wire logic SCLK_I, // bit clock pin, input
  output logic SCLK_O, // bit clock pin, output
  output logic SCLK_OE, // bit clock pin, enable
  output logic SERIAL_RESULT_OUTPUT, // serial data
  output logic SYNC, // frame marker
  output logic CONVERTING // conversion in progress
);
  localparam int CONV_CYC = `ADCSP_CONV_CYC;

  adcsp_bus_type bus;
  adcsp_cfg_type cfg;
  adcsp_state_type state_q;
  logic [1:0] mode_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [`ADCSP_RES_W-1:0] result_q;
  logic [`ADCSP_RES_W-1:0] sh_q;
  logic [`ADCSP_RES_W-1:0] load_val;
  logic [4:0] bit_q;
  logic [7:0] conv_cnt_q;
  logic conv_q;
  logic serial;
  logic int_clk;
  logic slow;
  logic conv_start;
  logic conv_end;
  logic seq_start;
  logic seq_end;
  logic frame_d;
  logic upd;
  logic ext_lvl;
  logic ext_lvl_q;
  logic gen_sclk_d;
  logic gen_rise;
  logic sclk_o_q;
  logic sclk_oe_q;
  logic sync_q;
  logic [5:0] pd_o_q;
  logic [5:0] pd_oe_q;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`ADCSP_RES_W-1:0] fifo_out_data;
  logic [4:0] fifo_count;
  logic bus_take;
  logic bus_done;

  // ************************************************************
  // configuration decode
  // ************************************************************
  assign bus = '{rd: READ, wr: WRITE, addr: ADDR, wdata: WRITEDATA};
  assign cfg = adcsp_cfg_type'(PD_I);
  assign serial = (mode_q == `ADCSP_MODE_SERIAL);
  assign int_clk = serial && !cfg.ext;
  assign slow = int_clk && !cfg.read_mode;

  // ************************************************************
  // register bus slave
  // ************************************************************
  // data writes are held off while the fifo is full
  assign bus_take = (bus.rd || bus.wr) && wait_q &&
                    !(bus.wr && bus.addr == `ADCSP_OFS_DATA && !fifo_in_ready);
  assign bus_done = (bus.rd || bus.wr) && !wait_q;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !bus_take;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_take && bus.rd) begin
      case (bus.addr)
        `ADCSP_OFS_CTRL: rdata_q <= {30'h0000_0000, mode_q};
        `ADCSP_OFS_DATA: rdata_q <= {14'h0000, result_q};
        `ADCSP_OFS_STAT: rdata_q <= {22'h00_0000, fifo_count, serial, !fifo_in_ready,
                                     !fifo_out_valid, state_q == ST_SHIFT, conv_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      mode_q <= `ADCSP_MODE_RESET;
    end else if (bus_done && bus.wr && bus.addr == `ADCSP_OFS_CTRL) begin
      mode_q <= bus.wdata[1:0];
    end
  end

  assign fifo_in_valid = bus_done && bus.wr && bus.addr == `ADCSP_OFS_DATA;

  // ************************************************************
  // result queue
  // ************************************************************
  adcsp_fifo #(
    .W(`ADCSP_RES_W),
    .DEPTH(`ADCSP_FIFO_DEPTH),
    .AW(`ADCSP_FIFO_AW)
  ) u_fifo (
    .clk(MCLK),
    .rst(RST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(bus.wdata[`ADCSP_RES_W-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(conv_end),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  // ************************************************************
  // conversion
  // ************************************************************
  // a start with an empty queue is ignored
  assign conv_start = bus_done && bus.wr && bus.addr == `ADCSP_OFS_CTRL &&
                      bus.wdata[`ADCSP_CTRL_START_BIT] && !conv_q && fifo_out_valid;
  assign conv_end = conv_q && (conv_cnt_q == 8'h00);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      conv_q <= 1'b0;
      conv_cnt_q <= 8'h00;
    end else if (conv_start) begin
      conv_q <= 1'b1;
      conv_cnt_q <= 8'(CONV_CYC - 1);
    end else if (conv_end) begin
      conv_q <= 1'b0;
    end else if (conv_q) begin
      conv_cnt_q <= conv_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      result_q <= '0;
    end else if (conv_end) begin
      result_q <= fifo_out_data;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      CONVERTING <= 1'b0;
    end else begin
      CONVERTING <= conv_start || (conv_q && !conv_end);
    end
  end

  // ************************************************************
  // read sequence
  // ************************************************************
  assign seq_start = serial && ((int_clk && cfg.read_mode && conv_start) ||
                                ((!int_clk || !cfg.read_mode) && conv_end));
  assign load_val = conv_end ? fifo_out_data : result_q;

  adcsp_sclk_gen u_sclk (
    .clk(MCLK),
    .rst(RST),
    .run(state_q == ST_SHIFT && int_clk && !seq_start),
    .slow(slow),
    .div(cfg.div),
    .sclk_d(gen_sclk_d),
    .rise(gen_rise)
  );

  // external clock is flipped when bit clock invert is set so one edge detector serves both
  assign ext_lvl = SCLK_I ^ cfg.inv_sclk;
  assign upd = (state_q == ST_SHIFT) && !seq_start &&
               (int_clk ? gen_rise : (ext_lvl && !ext_lvl_q));
  assign seq_end = upd && int_clk && (bit_q == `ADCSP_LAST_BIT);
  assign frame_d = seq_start || (state_q == ST_SHIFT && !seq_end);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ext_lvl_q <= 1'b0;
    end else begin
      ext_lvl_q <= ext_lvl;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (seq_start) state_q <= ST_SHIFT;
        // an external-clock sequence ends only at the next start or when serial mode is left
        ST_SHIFT: if (!serial || seq_end) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      sh_q <= '0;
      bit_q <= 5'h00;
    end else if (seq_start) begin
      sh_q <= load_val;
      bit_q <= 5'h00;
    end else if (seq_end || !serial) begin
      sh_q <= '0;
    end else if (upd) begin
      // chain input enters at the bottom and surfaces after a full word
      sh_q <= {sh_q[`ADCSP_RES_W-2:0], cfg.ext & cfg.read_mode};
      bit_q <= bit_q + 5'h01;
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sclk_o_q <= 1'b0;
      sclk_oe_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      sclk_oe_q <= int_clk;
      sclk_o_q <= int_clk && (gen_sclk_d ^ cfg.inv_sclk);
      sync_q <= serial && ((frame_d && int_clk) ^ cfg.inv_sync);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pd
      always_ff @(posedge MCLK) begin
        if (RST) begin
          pd_o_q[gi] <= 1'b0;
          pd_oe_q[gi] <= 1'b0;
        end else begin
          pd_o_q[gi] <= result_q[gi+4];
          pd_oe_q[gi] <= !serial;
        end
      end
    end
  endgenerate

  assign READDATA = rdata_q;
  assign WAITREQUEST = wait_q;
  assign PD_O = pd_o_q;
  assign PD_OE = pd_oe_q;
  assign SCLK_O = sclk_o_q;
  assign SCLK_OE = sclk_oe_q;
  assign SERIAL_RESULT_OUTPUT = sh_q[`ADCSP_RES_W-1];
  assign SYNC = sync_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_mode_pins;
    @(posedge MCLK) disable iff (RST)
    !serial |=> (PD_OE == 6'h3f) && (PD_O == $past(result_q[9:4]));
  endproperty
  a_mode_pins: assert property (p_mode_pins) else $error("parallel pins wrong");

  property p_serial_release;
    @(posedge MCLK) disable iff (RST)
    serial |=> (PD_OE == 6'h00);
  endproperty
  a_serial_release: assert property (p_serial_release) else $error("shared pins driven");

  property p_sclk_source;
    @(posedge MCLK) disable iff (RST)
    serial ##1 serial && $stable(cfg) |-> SCLK_OE == !cfg.ext;
  endproperty
  a_sclk_source: assert property (p_sclk_source) else $error("clock pin enable wrong");

  property p_msb_first;
    @(posedge MCLK) disable iff (RST)
    seq_start |=> (SERIAL_RESULT_OUTPUT == $past(load_val[17])) && (state_q == ST_SHIFT);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

  property p_frame_level;
    @(posedge MCLK) disable iff (RST)
    (state_q == ST_SHIFT) && int_clk && $stable(cfg) && $past(state_q == ST_SHIFT) |-> SYNC == !cfg.inv_sync;
  endproperty
  a_frame_level: assert property (p_frame_level) else $error("frame level wrong");

  property p_read_during;
    @(posedge MCLK) disable iff (RST)
    conv_start && int_clk && cfg.read_mode |=> (state_q == ST_SHIFT) && CONVERTING;
  endproperty
  a_read_during: assert property (p_read_during) else $error("no read during conversion");

  property p_read_after;
    @(posedge MCLK) disable iff (RST)
    int_clk && !cfg.read_mode && conv_q && !conv_end && (state_q == ST_IDLE) |=> (state_q == ST_IDLE);
  endproperty
  a_read_after: assert property (p_read_after) else $error("read started before end");

  property p_slow_clock;
    @(posedge MCLK) disable iff (RST)
    upd && slow && cfg.div == 2'h3 && !seq_end |=> !upd [*8];
  endproperty
  a_slow_clock: assert property (p_slow_clock) else $error("divided clock too fast");

  property p_chain_in;
    @(posedge MCLK) disable iff (RST)
    upd && cfg.ext && serial |=> sh_q[0] == $past(cfg.read_mode) && sh_q[17] == $past(sh_q[16]);
  endproperty
  a_chain_in: assert property (p_chain_in) else $error("chain shift wrong");

  property p_update_edge;
    @(posedge MCLK) disable iff (RST)
    int_clk && $stable(cfg) && $past(upd) && (state_q == ST_SHIFT) |-> SCLK_O == !cfg.inv_sclk;
  endproperty
  a_update_edge: assert property (p_update_edge) else $error("data not on active edge");

  // the data pin rests low between sequences, so no stale bits leak out
  property p_idle_quiet;
    @(posedge MCLK) disable iff (RST)
    (state_q == ST_IDLE) && $past(state_q == ST_IDLE) |-> !SERIAL_RESULT_OUTPUT;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("data pin active while idle");

  c_read_during: cover property (@(posedge MCLK) disable iff (RST) conv_start && int_clk && cfg.read_mode);
  c_read_after: cover property (@(posedge MCLK) disable iff (RST) seq_start && slow);
  c_chain: cover property (@(posedge MCLK) disable iff (RST) upd && cfg.ext && bit_q == 5'h12);
  c_fifo_full: cover property (@(posedge MCLK) disable iff (RST) !fifo_in_ready && bus.wr);
endmodule

/* test/adcsp_host_model.sv */
`timescale 1ns/100ps
module adcsp_host_model
  import adcsp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire adcsp_cfg_type cfg, // pin configuration
  input wire logic clr, // clear capture
  input wire logic go, // start 36 host clock periods
  input wire logic [17:0] chain_word, // word fed to chain input
  input wire logic sclk, // bit clock pin level
  input wire logic ser_out, // serial data
  input wire logic sync, // frame marker
  output logic sclk_i, // host bit clock
  output logic chain, // chain input level
  output logic [35:0] cap, // captured bits
  output logic [5:0] cnt, // bits captured
  output logic [9:0] span, // cycles from first to last bit
  output logic [5:0] sync_bad // bits seen without marker
);
  logic x, a, b, s;
  logic [2:0] ph;
  logic [5:0] nr;
  logic [9:0] cyc;
  logic [35:0] chs;
  wire logic line = cfg.ext ? x : (sclk ^ cfg.inv_sclk);
  assign sclk_i = x ^ cfg.inv_sclk;
  assign chain = chs[35];
  // ************************************************************
  // host bit clock, 6 cycles a period, low between frames before the invert pin is applied
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      ph <= 3'h0;
      nr <= 6'h0;
      x <= 1'b0;
      chs <= 36'h0;
    end else if (go) begin
      nr <= 6'h24;
      chs <= {chain_word, 18'h0};
    end else if (nr != 6'h0) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h2) x <= 1'b1;
      if (ph == 3'h5) begin
        x <= 1'b0;
        nr <= nr - 6'h1;
        chs <= chs << 1;
      end
    end
  end
  // ************************************************************
  // capture: data and marker as they stood before each rise
  // ************************************************************
  always_ff @(posedge clk) begin
    a <= line;
    b <= ser_out;
    s <= sync;
    if (rst || clr) begin
      cnt <= 6'h0;
      cyc <= 10'h0;
      span <= 10'h0;
      sync_bad <= 6'h0;
    end else begin
      if (cnt != 6'h0 || (line && !a)) cyc <= cyc + 10'h1;
      if (line && !a) begin
        cap <= {cap[34:0], b};
        cnt <= cnt + 6'h1;
        span <= cyc;
        if (!cfg.ext && s !== !cfg.inv_sync) sync_bad <= sync_bad + 6'h1;
      end
    end
  end
endmodule

/* test/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import adcsp_pkg::*;
;
  typedef struct packed {
    adcsp_cfg_type cfg;
    logic [17:0] res;
    logic [9:0] span;
  } adcsp_row_type;
  localparam logic [17:0] CHW = 18'h2c5a3;
  logic mclk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, clr = 1'b0, go = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic wreq, sclk_o, sclk_oe, ser_out, sync, conv, host_sclk, chain;
  logic [5:0] pd_o, pd_oe, cnt, sync_bad;
  logic [35:0] cap, e;
  logic [17:0] p;
  logic [9:0] span;
  adcsp_cfg_type cfg = 6'h00;
  int num_errors = 0, checks_done = 0, n;
  wire logic sclk_pin = sclk_oe ? sclk_o : host_sclk;
  wire logic [5:0] pd = (pd_oe & pd_o) | (~pd_oe & {cfg.ext ? chain : cfg.read_mode, cfg[4:0]});
  adcsp_row_type rows [6] = '{
    '{6'h00, 18'h2b3c5, 10'h022},
    '{6'h19, 18'h15a69, 10'h044},
    '{6'h0a, 18'h30f0f, 10'h088},
    '{6'h13, 18'h0c3a6, 10'h110},
    '{6'h06, 18'h2468a, 10'h0d2},
    '{6'h1c, 18'h1d2e7, 10'h0d2}};

  adcsp_top uut (.MCLK(mclk), .RST(rst), .ADDR(addr), .READ(rd), .WRITE(wr), .WRITEDATA(wdata),
    .READDATA(rdata), .WAITREQUEST(wreq), .PD_I(pd), .PD_O(pd_o), .PD_OE(pd_oe), .SCLK_I(sclk_pin),
    .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .SERIAL_RESULT_OUTPUT(ser_out), .SYNC(sync), .CONVERTING(conv));
  adcsp_host_model host (.clk(mclk), .rst(rst), .cfg(cfg), .clr(clr), .go(go), .chain_word(CHW),
    .sclk(sclk_pin), .ser_out(ser_out), .sync(sync), .sclk_i(host_sclk), .chain(chain), .cap(cap),
    .cnt(cnt), .span(span), .sync_bad(sync_bad));

  initial begin
    forever #20 mclk = ~mclk;
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task chk(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wreq !== 1'b0 && k < 100);
    if (wreq !== 1'b0) num_errors++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task wconv();
    cyc(3);
    n = 0;
    while (conv === 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 200) num_errors++;
  endtask
  task wbits(input logic [5:0] nb);
    int k;
    k = 0;
    while (cnt !== nb && k < 800) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 800) num_errors++;
    cyc(30);
  endtask
  task done(input string s);
    $display("test %s finished, mismatches so far %0d", s, num_errors);
  endtask
  task give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    cyc(20000);
    num_errors++;
    give_verdict();
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    cyc(2);
    chk({wreq, ser_out, sync, sclk_oe, pd_oe}, {4'h8, 6'h00});
    rst <= 1'b0;
    cyc(2);
    chk(pd_oe, 6'h3f);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h4);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h0, 32'h7);
    bus(1'b0, 4'h0, 32'h0);
    chk({q, conv}, {32'h3, 1'b0});
    bus(1'b0, 4'h8, 32'h0);
    chk({q, pd_oe, sclk_oe}, {32'h14, 6'h00, 1'b1});
    bus(1'b1, 4'h0, 32'h0);
    done("registers");
    for (int i = 0; i < 16; i++) bus(1'b1, 4'h4, {14'h0, 18'h2d2d2 - 18'h01357 * i[17:0]});
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h208);
    for (int i = 0; i < 16; i++) begin
      p = 18'h2d2d2 - 18'h01357 * i[17:0];
      bus(1'b1, 4'h0, 32'h4);
      wconv();
      cyc(2);
      bus(1'b0, 4'h4, 32'h0);
      chk({pd_oe, pd_o, q[17:0]}, {6'h3f, p[9:4], p});
    end
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h4);
    done("parallel");
    bus(1'b1, 4'h0, 32'h3);
    foreach (rows[r]) begin
      cfg <= rows[r].cfg; // only changed between frames
      clr <= 1'b1;
      bus(1'b1, 4'h4, {14'h0, rows[r].res});
      clr <= 1'b0;
      bus(1'b1, 4'h0, 32'h7);
      wconv();
      chk({cnt, n > 15}, {6'h0, 1'b1});
      if (rows[r].cfg.ext) begin
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
      end
      wbits(rows[r].cfg.ext ? 6'h24 : 6'h12);
      e = rows[r].cfg.ext ? {rows[r].res, CHW} : {18'h0, rows[r].res};
      chk(rows[r].cfg.ext ? cap : {18'h0, cap[17:0]}, e);
      chk({span, sync_bad, sync, sclk_oe}, {rows[r].span, 6'h0, rows[r].cfg.inv_sync, !rows[r].cfg.ext});
      chk(sclk_pin, rows[r].cfg.inv_sclk);
    end
    done("serial rows");
    // leaving serial mode closes the open external sequence in the same cycle as the pins change
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h0, 32'h3);
    cfg <= 6'h23;
    clr <= 1'b1;
    bus(1'b1, 4'h4, 32'h3c3c3);
    clr <= 1'b0;
    bus(1'b1, 4'h0, 32'h7);
    cyc(6);
    chk({conv, cnt != 6'h0}, 2'h3);
    wbits(6'h12);
    chk({cap[17:0], span, sync_bad}, {rows[5].res, 10'h022, 6'h0});
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h3c3c3);
    done("read during conversion");
    cfg <= 6'h00;
    bus(1'b1, 4'h4, 32'h2aaaa);
    bus(1'b1, 4'h0, 32'h7);
    wconv();
    cyc(6);
    rst <= 1'b1;
    cyc(2);
    chk({wreq, ser_out, sync, sclk_oe, conv}, 5'h10);
    rst <= 1'b0;
    cyc(2);
    chk(pd_oe, 6'h3f);
    done("reset mid frame");
    give_verdict();
  end
endmodule
